// ### rtl/msps_defines.svh
// constants of the multiphase pwm sequencer: offsets, fields, resets, timing
// assumes a 100 MHz system clock; included by bare name
`ifndef MSPS_DEFINES_SVH
`define MSPS_DEFINES_SVH
// timing
`define MSPS_CLK_NS       10
`define MSPS_SS_TIME_NS   100000
`define MSPS_SS_CYCLES    (`MSPS_SS_TIME_NS / `MSPS_CLK_NS)
`define MSPS_PERIOD_RST   16'h012c
`define MSPS_PERIOD_MIN   16'h0006
// register offsets
`define MSPS_OFS_PERIOD   4'h0
`define MSPS_OFS_STATUS   4'h4
`define MSPS_OFS_MASK     4'h8
`define MSPS_OFS_INFO     4'hc
// status and mask bit positions
`define MSPS_EV_OC        0
`define MSPS_EV_OV        1
`define MSPS_EV_UV        2
`define MSPS_EV_SS        3
`define MSPS_EV_W         4
`define MSPS_MASK_RST     4'h0
// info fields
`define MSPS_INFO_REF     0
`define MSPS_INFO_OFF     12
`define MSPS_INFO_TBL     13
`define MSPS_INFO_PH      16
`define MSPS_INFO_PG      18
// code tables: base mV at code max-1, step mV per code
`define MSPS_ALT_BASE     16'd800
`define MSPS_ALT_STEP     16'd25
`define MSPS_ALT_MAX      16'd31
`define MSPS_FIRST_BASE   16'd1100
`define MSPS_FIRST_STEP   16'd25
`define MSPS_FIRST_MAX    16'd31
`define MSPS_THIRD_BASE   16'd825
`define MSPS_THIRD_STEP   16'd13
`define MSPS_THIRD_MAX    16'd63
`endif

// ### rtl/msps_pkg.sv
// types of the multiphase pwm sequencer
// assumes nothing beyond the defines header
package msps_pkg;
  typedef enum logic [1:0] {TBL_THIRD, TBL_FIRST, TBL_ALT} msps_table_t;
  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_FAULT} msps_state_t;
  typedef struct packed {
    logic [5:0] code;
    logic       stdSel;
    logic       halfStep;
  } msps_ident_t;
  typedef struct packed {
    logic       off;
    logic [11:0] mv;
  } msps_ref_t;
endpackage

// ### rtl/msps_sequencer.sv
// sequencing core of a one-to-three phase interleaved buck controller
// assumes raw pin inputs, one 100 MHz clock, plain register port
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "msps_defines.svh"
module msps_sequencer
  import msps_pkg::*;
#(
  parameter int SS_CYCLES = `MSPS_SS_CYCLES
)
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // straps and enable pins
  input  wire logic              phaseTwoSupplyStrap,
  input  wire logic              phaseThreeSupplyStrap,
  input  wire logic              controllerEnableIn,
  // identification pins
  input  wire msps_pkg::msps_ident_t identIn,
  // comparators and monitors
  input  wire logic              overcurrentTrip,
  input  wire logic              overVoltage,
  input  wire logic              underVoltage,
  input  wire logic [2:0]        modulatorCross,
  input  wire logic [2:0]        upperGateSense,
  // gate, pulse, power-good and reference outputs
  output logic [2:0]             phasePulse,
  output logic [2:0]             upperGate,
  output logic [2:0]             lowerGate,
  output logic                   powerGoodOut,
  output msps_pkg::msps_ref_t    refSetting,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  output logic                   irq
);
  import msps_pkg::*;

  // ssCnt_r is sixteen bits, so a longer soft-start cannot be counted
  if (SS_CYCLES < 1 || SS_CYCLES > 65535)
  begin : gBadSoftStart
    $error("soft-start count out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change accepted once stages two and three agree
  localparam int NIN = 20;
  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic [NIN-1:0] s3_r;
  logic [NIN-1:0] pin_r;
  assign pinRaw = {upperGateSense, modulatorCross, underVoltage, overVoltage,
                   overcurrentTrip, identIn, controllerEnableIn,
                   phaseThreeSupplyStrap, phaseTwoSupplyStrap};

  genvar g;
  generate
    for (g = 0; g < NIN; g++)
    begin : gSync
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          pin_r[g] <= 1'b0;
        end
        else
        begin
          s1_r[g] <= pinRaw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            pin_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  logic        strap2;
  logic        strap3;
  logic        enIn;
  msps_ident_t ident;
  logic        ocIn;
  logic        ovIn;
  logic        uvIn;
  logic [2:0]  crossIn;
  logic [2:0]  upSense;
  assign {upSense, crossIn, uvIn, ovIn, ocIn, ident, enIn, strap3, strap2} = pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // code table selection and decode
  msps_table_t tblSel;
  always_comb
  begin
    if (ident.stdSel)
      tblSel = TBL_THIRD;
    else if (ident.halfStep)
      tblSel = TBL_FIRST;
    else
      tblSel = TBL_ALT;
  end

  // all-ones code switches the reference off in every table
  function automatic msps_ref_t refDecode(msps_table_t t, logic [5:0] c);
    logic [15:0] base;
    logic [15:0] step;
    logic [15:0] top;
    logic [15:0] code;
    logic [15:0] mv;
    base = `MSPS_THIRD_BASE;
    step = `MSPS_THIRD_STEP;
    top  = `MSPS_THIRD_MAX;
    code = {10'h000, c};
    case (t)
      TBL_FIRST:
      begin
        base = `MSPS_FIRST_BASE;
        step = `MSPS_FIRST_STEP;
        top  = `MSPS_FIRST_MAX;
        code = {11'h000, c[4:0]};
      end
      TBL_ALT:
      begin
        base = `MSPS_ALT_BASE;
        step = `MSPS_ALT_STEP;
        top  = `MSPS_ALT_MAX;
        code = {11'h000, c[4:0]};
      end
      default:
      begin
        base = `MSPS_THIRD_BASE;
      end
    endcase
    mv = 16'(base + 16'(step * 16'(top - 16'h0001 - code)));
    refDecode.off = (code == top);
    refDecode.mv  = (code == top) ? 12'h000 : mv[11:0];
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      refSetting <= '0;
    else
      refSetting <= refDecode(tblSel, ident.code);
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase count
  logic [1:0] phases;
  always_comb
  begin
    if (!strap2)
      phases = 2'h1;
    else if (!strap3)
      phases = 2'h2;
    else
      phases = 2'h3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]         period_r;
  logic [`MSPS_EV_W-1:0] status_r;
  logic [`MSPS_EV_W-1:0] mask_r;
  logic [`MSPS_EV_W-1:0] events;
  logic                wrPeriod;
  logic                wrStatus;
  logic                wrMask;
  assign wrPeriod = regWr && regAddr == `MSPS_OFS_PERIOD;
  assign wrStatus = regWr && regAddr == `MSPS_OFS_STATUS;
  assign wrMask   = regWr && regAddr == `MSPS_OFS_MASK;

  // too short a period would collapse the thirds; such writes are dropped
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      period_r <= `MSPS_PERIOD_RST;
    else if (wrPeriod && regWdata[15:0] >= `MSPS_PERIOD_MIN)
      period_r <= regWdata[15:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mask_r <= `MSPS_MASK_RST;
    else if (wrMask)
      mask_r <= regWdata[`MSPS_EV_W-1:0];
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_r <= '0;
    else if (wrStatus)
      status_r <= (status_r & ~regWdata[`MSPS_EV_W-1:0]) | events;
    else
      status_r <= status_r | events;
  end

  assign irq = |(status_r & mask_r);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      regRdata <= '0;
    else if (!regRd)
      regRdata <= '0;
    else
      case (regAddr)
        `MSPS_OFS_PERIOD: regRdata <= {16'h0000, period_r};
        `MSPS_OFS_STATUS: regRdata <= {28'h0000000, status_r};
        `MSPS_OFS_MASK:   regRdata <= {28'h0000000, mask_r};
        `MSPS_OFS_INFO:   regRdata <= {13'h0000, powerGoodOut, phases,
                                       1'b0, tblSel, refSetting};
        default:          regRdata <= '0;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state
  msps_state_t state_r;
  logic [15:0] ssCnt_r;
  logic        running;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_OFF;
      ssCnt_r <= '0;
    end
    else if (!enIn)
    begin
      state_r <= ST_OFF;
      ssCnt_r <= '0;
    end
    else
      case (state_r)
        ST_OFF:
          if (!refSetting.off)
            state_r <= ST_SOFT;
        ST_SOFT:
          if (ocIn)
            state_r <= ST_FAULT;
          else if (ssCnt_r == 16'(SS_CYCLES - 1))
            state_r <= ST_RUN;
          else
            ssCnt_r <= ssCnt_r + 16'h0001;
        ST_RUN:
          if (ocIn)
            state_r <= ST_FAULT;
          else if (refSetting.off)
            state_r <= ST_OFF;
        // latched off; only dropping enable restarts the converter
        ST_FAULT:
          state_r <= ST_FAULT;
        default:
          state_r <= ST_OFF;
      endcase
  end
  assign running = (state_r == ST_SOFT) || (state_r == ST_RUN);

  always_comb
  begin
    events = '0;
    events[`MSPS_EV_OC] = running && ocIn;
    events[`MSPS_EV_OV] = ovIn;
    events[`MSPS_EV_UV] = uvIn && state_r == ST_RUN;
    events[`MSPS_EV_SS] = state_r == ST_SOFT && ssCnt_r == 16'(SS_CYCLES - 1)
                          && !ocIn;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      powerGoodOut <= 1'b0;
    else
      powerGoodOut <= state_r == ST_RUN && !ovIn && !uvIn && !ocIn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle counter and termination instants
  logic [15:0] cyc_r;
  logic [15:0] third;
  logic [15:0] half;
  logic [2:0]  term;
  logic [2:0]  active;
  assign third = period_r / 16'd3;
  assign half  = period_r >> 1;

  always_ff @(posedge sys_clk)
  begin
    if (rst || !running)
      cyc_r <= '0;
    else if (cyc_r >= period_r - 16'h0001)
      cyc_r <= '0;
    else
      cyc_r <= cyc_r + 16'h0001;
  end

  assign term[0] = cyc_r == 16'h0000;
  assign term[1] = cyc_r == ((phases == 2'h2) ? half : third);
  assign term[2] = cyc_r == 16'(third << 1);
  assign active  = (phases == 2'h3) ? 3'h7 : (phases == 2'h2) ? 3'h3 : 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel pulse and gate logic
  generate
    for (g = 0; g < 3; g++)
    begin : gCh
      logic [15:0] offCnt_r;
      logic        chOn;
      assign chOn = running && active[g];

      // forced low holds at least a third, so on-time stays under two thirds
      always_ff @(posedge sys_clk)
      begin
        if (rst || !chOn)
        begin
          phasePulse[g] <= 1'b0;
          offCnt_r      <= third;
        end
        else if (term[g])
        begin
          phasePulse[g] <= 1'b0;
          offCnt_r      <= third;
        end
        else if (offCnt_r != 16'h0000)
          offCnt_r <= offCnt_r - 16'h0001;
        else if (crossIn[g])
          phasePulse[g] <= 1'b1;
      end

      // upper waits for lower off; lower waits for sensed upper off
      always_ff @(posedge sys_clk)
      begin
        if (rst || !chOn)
        begin
          upperGate[g] <= 1'b0;
          lowerGate[g] <= 1'b0;
        end
        else
        begin
          upperGate[g] <= phasePulse[g] && !lowerGate[g];
          lowerGate[g] <= !phasePulse[g] && !upperGate[g] && !upSense[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### verif/msps_sequencer_properties.sv
// checker: gate, pulse spacing and power-good timing
// assumes binding onto msps_sequencer; period mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
module msps_sequencer_properties (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // pins
  input wire logic        phaseThreeSupplyStrap,
  input wire logic        controllerEnableIn,
  input wire logic        overcurrentTrip,
  input wire logic        overVoltage,
  input wire logic        underVoltage,
  input wire logic [2:0]  phasePulse,
  input wire logic [2:0]  upperGate,
  input wire logic [2:0]  lowerGate,
  input wire logic        powerGoodOut,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr
);
  logic [15:0] periodR;
  logic [15:0] offCnt;
  logic [15:0] sinceFall;
  logic [3:0]  lowCnt;
  logic        prevR;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
    if (rst)
      periodR <= 16'h012c;
    else if (regWr && regAddr == 4'h0 && regWdata[15:0] >= 16'h0006)
      periodR <= regWdata[15:0];
  // saturating, so a long idle stretch never wraps into a false short gap
  always_ff @(posedge sys_clk)
    offCnt <= (rst || phasePulse[0]) ? 16'h0 : offCnt + {15'h0, offCnt != 16'hffff};
  always_ff @(posedge sys_clk)
    lowCnt <= (rst || controllerEnableIn) ? 4'h0 : lowCnt + {3'h0, lowCnt != 4'hf};
  always_ff @(posedge sys_clk)
    prevR <= !rst && phasePulse[0];
  // cleared around shutdowns, where every pulse drops at once
  always_ff @(posedge sys_clk)
    if (rst || !powerGoodOut || overcurrentTrip || !controllerEnableIn)
      sinceFall <= 16'h0;
    else if (prevR && !phasePulse[0])
      sinceFall <= 16'h1;
    else if (sinceFall != 16'h0)
      sinceFall <= sinceFall + 16'h1;
  ////////////////////////////////////////////////////////////
  gate_overlap_a: assert property ((upperGate & lowerGate) == 3'h0)
    else $error("upper and lower gate on together");
  upper_after_pulse_a: assert property ($rose(upperGate[0]) |-> $past(phasePulse[0]))
    else $error("upper gate rose without pulse");
  lower_after_upper_a: assert property ($rose(lowerGate[0]) |->
    !$past(upperGate[0]) && !$past(phasePulse[0])) else $error("lower gate rose too early");
  enable_stop_a: assert property (lowCnt >= 4'h8 |-> phasePulse == 3'h0 && !powerGoodOut)
    else $error("converter active while disabled");
  pg_window_a: assert property (overVoltage [*8] |-> !powerGoodOut)
    else $error("power good high during overvoltage");
  pg_under_a: assert property (underVoltage [*8] |-> !powerGoodOut)
    else $error("power good high during undervoltage");
  oc_response_a: assert property (overcurrentTrip [*8] |=>
    phasePulse == 3'h0 && !powerGoodOut) else $error("no shutdown on overcurrent");
  forced_off_a: assert property ($rose(phasePulse[0]) |-> offCnt >= periodR / 16'h3)
    else $error("forced off time too short");
  phase_spacing_a: assert property ($fell(phasePulse[1]) && sinceFall != 16'h0 |->
    sinceFall == (phaseThreeSupplyStrap ? periodR / 16'h3 : periodR / 16'h2))
    else $error("wrong phase spacing");
  cover property ($fell(phasePulse[1]) && sinceFall != 16'h0);
  cover property ($rose(powerGoodOut));
  cover property ($rose(lowerGate[0]));
endmodule
bind msps_sequencer msps_sequencer_properties chk (.sys_clk, .rst, .phaseThreeSupplyStrap,
  .controllerEnableIn, .overcurrentTrip, .overVoltage, .underVoltage, .phasePulse, .upperGate,
  .lowerGate,
  .powerGoodOut, .regAddr, .regWdata, .regWr);
`default_nettype wire

// ### verif/msps_power_stage.sv
// power stage model: upper gate feedback and modulator crossings
// assumes gate commands from the sequencer; one system clock
`timescale 1ns/1ps
`default_nettype none
module msps_power_stage (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // gate commands, speed choice and crossing hold
  input wire logic [2:0] upperGate,
  input wire logic       lagSense,
  input wire logic       holdCross,
  // feedback to the sequencer
  output logic [2:0]     upperGateSense,
  output logic [2:0]     modulatorCross
);
  logic [2:0] senseR;
  logic [2:0] senseR2;
  always_ff @(posedge sys_clk)
  begin
    senseR  <= rst ? 3'h0 : upperGate;
    senseR2 <= rst ? 3'h0 : senseR;
  end
  // slow mode: gate discharges a cycle later, so the lower switch must wait
  assign upperGateSense = lagSense ? senseR2 : senseR;
  // demand above the ramp: widest pulse the forced off allows; hold keeps it below
  assign modulatorCross = holdCross ? 3'h0 : 3'h7;
endmodule
`default_nettype wire

// ### verif/multiphase_pwm_sequencer_bench.sv
// self-checking bench of the pwm sequencer
// assumes the stage model beside it and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module multiphase_pwm_sequencer_bench;
  import msps_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic        phaseTwoSupplyStrap;
  logic        phaseThreeSupplyStrap;
  logic        controllerEnableIn;
  msps_ident_t identIn;
  logic        overcurrentTrip;
  logic        overVoltage;
  logic        underVoltage;
  logic        lagSense;
  logic        holdCross;
  logic [2:0]  modulatorCross;
  logic [2:0]  upperGateSense;
  logic [2:0]  phasePulse;
  logic [2:0]  upperGate;
  logic [2:0]  lowerGate;
  logic        powerGoodOut;
  msps_ref_t   refSetting;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        irq;
  int          n_errors = 0;
  int          tests_run = 0;
  // pins, millivolts, table code: third twice, third off code, first, alternate
  logic [22:0] tab [5] = '{{8'hfa, 13'h0339, 2'h0}, {8'h03, 13'h065f, 2'h0},
                           {8'hfe, 13'h1000, 2'h0},
                           {8'hf9, 13'h044c, 2'h1}, {8'h30, 13'h04e2, 2'h2}};
  msps_sequencer #(.SS_CYCLES(20)) uut (.sys_clk, .rst, .phaseTwoSupplyStrap,
    .phaseThreeSupplyStrap, .controllerEnableIn, .identIn, .overcurrentTrip, .overVoltage,
    .underVoltage, .modulatorCross, .upperGateSense, .phasePulse, .upperGate, .lowerGate,
    .powerGoodOut, .refSetting, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);
  msps_power_stage stage (.sys_clk, .rst, .upperGate, .lagSense, .holdCross,
    .upperGateSense, .modulatorCross);
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // extra edge so a following write never re-raises the strobe in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_expect(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(posedge sys_clk);
    check(regRdata & m, e);
  endtask
  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: return {19'h0, refSetting};
      1: return {31'h0, powerGoodOut};
      3: return {29'h0, phasePulse};
      default: return {31'h0, irq};
    endcase
  endfunction
  task automatic settle(input int sel, input logic [31:0] e);
    int i;
    for (i = 0; i < 400 && probe(sel) !== e; i++)
      @(posedge sys_clk);
    if (i == 400)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: probe %0d never settled", $time, sel);
      tally_and_finish();
    end
    else
      check(probe(sel), e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    phaseTwoSupplyStrap = 1'b1;
    phaseThreeSupplyStrap = 1'b1;
    controllerEnableIn = 1'b0;
    identIn = 8'h30;
    overcurrentTrip = 1'b0;
    overVoltage = 1'b0;
    underVoltage = 1'b0;
    lagSense = 1'b0;
    holdCross = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_expect(4'h0, 32'hffff, 32'h012c);
    rd_expect(4'h2, 32'hffffffff, 32'h0);
    wr(4'h0, 32'h1e);
    wr(4'h0, 32'h5);
    rd_expect(4'h0, 32'hffff, 32'h1e);
    for (int k = 0; k < 5; k++)
    begin
      identIn <= tab[k][22:15];
      settle(0, {19'h0, tab[k][14:2]});
      rd_expect(4'hc, 32'h6000, {17'h0, tab[k][1:0], 13'h0});
    end
    wr(4'h8, 32'h8);
    controllerEnableIn <= 1'b1;
    settle(1, 32'h1);
    settle(2, 32'h1);
    rd_expect(4'hc, 32'h30000, 32'h30000);
    wr(4'h8, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(4'h4, 32'h8);
    wr(4'h8, 32'h8);
    check({31'h0, irq}, 32'h0);
    repeat (100) @(posedge sys_clk);
    overVoltage <= 1'b1;
    settle(1, 32'h0);
    rd_expect(4'h4, 32'h2, 32'h2);
    repeat (4) @(posedge sys_clk);
    overVoltage <= 1'b0;
    settle(1, 32'h1);
    underVoltage <= 1'b1;
    settle(1, 32'h0);
    rd_expect(4'h4, 32'h4, 32'h4);
    repeat (4) @(posedge sys_clk);
    underVoltage <= 1'b0;
    settle(1, 32'h1);
    overcurrentTrip <= 1'b1;
    settle(1, 32'h0);
    repeat (4) @(posedge sys_clk);
    overcurrentTrip <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check({28'h0, phasePulse, powerGoodOut}, 32'h0);
    rd_expect(4'h4, 32'h1, 32'h1);
    // latched fault only leaves through the enable pin
    controllerEnableIn <= 1'b0;
    phaseThreeSupplyStrap <= 1'b0;
    lagSense <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check({29'h0, phasePulse}, 32'h0);
    controllerEnableIn <= 1'b1;
    settle(1, 32'h1);
    rd_expect(4'hc, 32'h30000, 32'h20000);
    repeat (100) @(posedge sys_clk);
    controllerEnableIn <= 1'b0;
    phaseTwoSupplyStrap <= 1'b0;
    repeat (10) @(posedge sys_clk);
    controllerEnableIn <= 1'b1;
    settle(1, 32'h1);
    rd_expect(4'hc, 32'h30000, 32'h10000);
    repeat (60) @(posedge sys_clk);
    check({30'h0, phasePulse[2:1]}, 32'h0);
    // no modulator trip: pulse stays low after its termination
    holdCross <= 1'b1;
    repeat (60) @(posedge sys_clk);
    check({29'h0, phasePulse}, 32'h0);
    holdCross <= 1'b0;
    settle(3, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
